/* bcdc_checker.sv */
// Purpose: port-level checks for bcdc_counter
// Assumes: one aclk domain, aresetn active low
// Notes: blanking checked at its three-cycle minimum
`default_nettype none
module bcdc_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] digit_drive,
    input wire logic bcd_oe,
    input wire logic carry_borrow,
    input wire logic zero_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------
    // properties
    // ----------
    one_digit_a: assert property ($onehot0(digit_drive))
        else $error("two digits driven");
    blank_gap_a: assert property ((digit_drive != 4'h0 &&
        $changed(digit_drive)) |-> $past(digit_drive) == 4'h0)
        else $error("digit change without blanking");
    blank_len_a: assert property ($fell(|digit_drive) |->
        (digit_drive == 4'h0) [*3])
        else $error("blanking too short");
    // after digit two only the lsd may light
    scan_down_a: assert property (($fell(digit_drive[1]) && bcd_oe)
        |=> (digit_drive[3:1] == 3'h0) [*5])
        else $error("scan order wrong");
    wrap_width_a: assert property ($rose(carry_borrow) |->
        carry_borrow [*4] ##1 !carry_borrow)
        else $error("carry pulse width wrong");
    zero_rst_a: assert property ($rose(aresetn) |->
        ##[1:3] !zero_n)
        else $error("zero flag missing after reset");
    wr_answer_a: assert property ((s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property ((s_axi_arvalid && s_axi_arready)
        |=> s_axi_rvalid)
        else $error("read response late");
endmodule : bcdc_checker
bind bcdc_counter bcdc_checker u_chk (
    .aclk, .aresetn, .digit_drive, .bcd_oe, .carry_borrow, .zero_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);
`default_nettype wire

/* bcdc_counter.sv */
// Purpose: four-decade bcd up/down counter, compare, latch, display scan
// Assumes: all inputs synchronous to aclk; control mirrored in axi regs
// Notes: three-level controls are two bits each (lo, hi); neither = open
//
// Overview of operation
// - pulse carry/borrow when count wraps 9999 to 0000 or back
// - carry/borrow may be ignored during loads and reset
// - reset from 6000 or above also gives a carry/borrow pulse
// - equal output low when counter matches register
// - zero output low when counter is 0000
// - display: open blanks leading zeros, high off, low shows zeros
// - each scan pulse advances a four-state digit phase
// - digit drivers off during the short scan pulse
// - digits scanned from most to least significant
// - loads run on the internal oscillator, external scan ignored
// - count edge increments when direction high, else decrements
// - count edges ignored during reset or counter load
// - store low copies counter to latch; outputs show latch
// - reset low clears counter directly, not via the bcd input path
// - register load during reset loads zero
// - bcd port loads counter/register per controls, else outputs
// - common-cathode inputs are low-true
// - with loads open bcd port outputs latch per phase, msd first
// - load starts at msd, four phases, resample, repeat or resume
// - register-load low stops scan, floats port, display off
// - reset never clears the register
`default_nettype none
module bcdc_counter #(
    parameter int unsigned SCAN_PERIOD = bcdc_pkg::SCAN_PERIOD_CYC,
    parameter int unsigned SCAN_PULSE = bcdc_pkg::SCAN_PULSE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic count_in,
    input wire logic ext_scan,
    input wire logic [3:0] bcd_in,
    output logic [3:0] bcd_out,
    output logic bcd_oe,
    output logic [6:0] segments,
    output logic [3:0] digit_drive,
    output logic carry_borrow,
    output logic equal_n,
    output logic zero_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------
    // functions
    // ----------
    function automatic logic [6:0] bcdc_seg(input logic [3:0] d);
        case (d)
            4'h0: bcdc_seg = 7'h3f;
            4'h1: bcdc_seg = 7'h06;
            4'h2: bcdc_seg = 7'h5b;
            4'h3: bcdc_seg = 7'h4f;
            4'h4: bcdc_seg = 7'h66;
            4'h5: bcdc_seg = 7'h6d;
            4'h6: bcdc_seg = 7'h7d;
            4'h7: bcdc_seg = 7'h07;
            4'h8: bcdc_seg = 7'h7f;
            4'h9: bcdc_seg = 7'h6f;
            default: bcdc_seg = 7'h00;
        endcase
    endfunction : bcdc_seg

    function automatic logic [3:0] bcdc_dig(input logic [15:0] v,
                                            input logic [1:0] p);
        bcdc_dig = v[{p, 2'b00} +: 4];
    endfunction : bcdc_dig

    // ----------
    // register bus
    // ----------
    logic [31:0] ctrl;
    logic [15:0] count;
    logic [15:0] compare;
    logic [15:0] latch;
    logic aw_hold, w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            ctrl <= bcdc_pkg::CTRL_RESET;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_hold && w_hold) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr == bcdc_pkg::ADDR_CTRL) begin
                    s_axi_bresp <= 2'b00;
                    for (int i = 0; i < 4; i++) begin
                        if (w_strb[i]) begin
                            ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
                        end
                    end
                end else begin
                    s_axi_bresp <= 2'b10;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------
    // control decode
    // ----------
    logic direction, store_n, reset_n, ext_sel, cc_variant;
    logic load_counter_ctl, load_register_ctl, lr_off, disp_off, show_zeros;
    assign direction = ctrl[bcdc_pkg::CTRL_DIR];
    assign store_n = !ctrl[bcdc_pkg::CTRL_STORE_N];
    assign reset_n = !ctrl[bcdc_pkg::CTRL_RESET_N];
    assign load_counter_ctl = ctrl[bcdc_pkg::CTRL_LC_HI];
    assign load_register_ctl = ctrl[bcdc_pkg::CTRL_LR_HI];
    assign lr_off = ctrl[bcdc_pkg::CTRL_LR_LO] && !load_register_ctl;
    assign disp_off = ctrl[bcdc_pkg::CTRL_DISP_HI];
    assign show_zeros = ctrl[bcdc_pkg::CTRL_DISP_LO] && !disp_off;
    assign ext_sel = ctrl[bcdc_pkg::CTRL_EXT_SCAN];
    assign cc_variant = ctrl[bcdc_pkg::CTRL_CC];

    // ----------
    // scan oscillator and phase sequencer
    // ----------
    bcdc_pkg::bcdc_mode_e mode;
    logic [15:0] osc_cnt;
    logic osc_pulse, scan_pulse, scan_prev, scan_edge;
    logic [1:0] phase;
    logic [1:0] load_left;
    logic load_cnt_act, load_reg_act, start_load;

    assign osc_pulse = osc_cnt < 16'(SCAN_PULSE);
    assign start_load = mode == bcdc_pkg::BCDC_RUN &&
                        (load_counter_ctl || load_register_ctl);
    // loads always use the internal oscillator
    assign scan_pulse = (ext_sel && mode != bcdc_pkg::BCDC_LOAD) ?
                        ext_scan : osc_pulse;
    assign scan_edge = scan_pulse && !scan_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_cnt <= 16'h0000;
            scan_prev <= 1'b0;
        end else if (clk_en) begin
            if (mode == bcdc_pkg::BCDC_OFF) begin
                osc_cnt <= 16'(SCAN_PULSE); // oscillator stopped
                scan_prev <= 1'b0;
            end else if (start_load) begin
                // restart so the msd gets a whole digit time
                osc_cnt <= 16'h0000;
                scan_prev <= 1'b1;
            end else begin
                osc_cnt <= (osc_cnt == 16'(SCAN_PERIOD - 1)) ? 16'h0000
                                                             : osc_cnt + 16'h1;
                scan_prev <= scan_pulse;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= bcdc_pkg::BCDC_RUN;
            phase <= bcdc_pkg::PHASE_MSD;
            load_left <= 2'h0;
            load_cnt_act <= 1'b0;
            load_reg_act <= 1'b0;
        end else if (clk_en) begin
            case (mode)
                bcdc_pkg::BCDC_RUN: begin
                    if (start_load) begin
                        mode <= bcdc_pkg::BCDC_LOAD; // restart at msd
                        phase <= bcdc_pkg::PHASE_MSD;
                        load_left <= 2'h3;
                        load_cnt_act <= load_counter_ctl;
                        load_reg_act <= load_register_ctl;
                    end else if (lr_off) begin
                        mode <= bcdc_pkg::BCDC_OFF;
                    end else if (scan_edge) begin
                        phase <= phase - 2'h1; // msd down to lsd
                    end
                end
                bcdc_pkg::BCDC_LOAD: begin
                    if (scan_edge) begin
                        phase <= phase - 2'h1;
                        load_left <= load_left - 2'h1;
                        if (load_left == 2'h0) begin
                            // resample controls after four phases
                            if (load_counter_ctl || load_register_ctl) begin
                                load_left <= 2'h3;
                                load_cnt_act <= load_counter_ctl;
                                load_reg_act <= load_register_ctl;
                            end else begin
                                mode <= bcdc_pkg::BCDC_RUN;
                                load_cnt_act <= 1'b0;
                                load_reg_act <= 1'b0;
                            end
                        end
                    end
                end
                bcdc_pkg::BCDC_OFF: begin
                    if (!lr_off) begin
                        mode <= bcdc_pkg::BCDC_RUN;
                    end
                end
                default: mode <= bcdc_pkg::BCDC_RUN;
            endcase
        end
    end

    // ----------
    // bcd input path
    // ----------
    logic [3:0] in_digit;
    logic load_strobe;
    // low-true data on common-cathode parts
    // reset forces the shared input path to zero
    assign in_digit = !reset_n ? 4'h0 : (cc_variant ? ~bcd_in : bcd_in);
    // digit taken at the trailing end of its phase
    assign load_strobe = (mode == bcdc_pkg::BCDC_LOAD) && scan_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare <= bcdc_pkg::REG_RESET;
        end else if (clk_en && load_strobe && load_reg_act) begin
            compare[{phase, 2'b00} +: 4] <= in_digit;
        end
    end

    // ----------
    // counter
    // ----------
    logic count_prev, count_edge, cnt_load;
    logic [15:0] next_count;
    logic [4:0] carry;
    logic [7:0] wrap_cnt;
    logic reset_wrap;

    assign count_edge = count_in && !count_prev;
    assign cnt_load = load_cnt_act && mode == bcdc_pkg::BCDC_LOAD;
    assign reset_wrap = !reset_n && (count[15:12] >= 4'h6) &&
                        (count != bcdc_pkg::COUNT_RESET);

    // decade cascade
    always_comb begin
        carry = 5'b00001;
        next_count = count;
        for (int i = 0; i < 4; i++) begin
            if (carry[i]) begin
                if (direction) begin
                    next_count[i*4 +: 4] = (count[i*4 +: 4] >= 4'h9) ? 4'h0
                                           : count[i*4 +: 4] + 4'h1;
                    carry[i+1] = count[i*4 +: 4] >= 4'h9;
                end else begin
                    next_count[i*4 +: 4] = (count[i*4 +: 4] == 4'h0) ? 4'h9
                                           : count[i*4 +: 4] - 4'h1;
                    carry[i+1] = count[i*4 +: 4] == 4'h0;
                end
            end else begin
                carry[i+1] = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= bcdc_pkg::COUNT_RESET;
            count_prev <= 1'b0;
        end else if (clk_en) begin
            count_prev <= count_in;
            if (!reset_n) begin
                count <= bcdc_pkg::COUNT_RESET;
            end else if (cnt_load) begin
                if (load_strobe) begin
                    count[{phase, 2'b00} +: 4] <= in_digit;
                end
            end else if (count_edge) begin
                count <= next_count;
            end
        end
    end

    // wrap pulse; undefined during load/reset windows
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_cnt <= 8'h00;
        end else if (clk_en) begin
            if ((reset_n && !cnt_load && count_edge && carry[4]) ||
                reset_wrap) begin
                wrap_cnt <= 8'(bcdc_pkg::WRAP_PULSE_CYC);
            end else if (wrap_cnt != 8'h00) begin
                wrap_cnt <= wrap_cnt - 8'h1;
            end
        end
    end

    // ----------
    // latch, flags and display
    // ----------
    logic [3:0] cur_digit;
    logic lead_blank;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch <= bcdc_pkg::COUNT_RESET;
            carry_borrow <= 1'b0;
            equal_n <= 1'b1;
            zero_n <= 1'b1;
        end else if (clk_en) begin
            if (!store_n) begin
                latch <= count;
            end
            carry_borrow <= wrap_cnt != 8'h00;
            equal_n <= !(count == compare);
            zero_n <= !(count == 16'h0000);
        end
    end

    assign cur_digit = bcdc_dig(latch, phase);
    // zero is leading if it and every higher digit is zero, except the lsd
    always_comb begin
        lead_blank = 1'b1;
        for (int i = 3; i >= 0; i--) begin
            if (2'(i) >= phase && latch[i*4 +: 4] != 4'h0) begin
                lead_blank = 1'b0;
            end
        end
        if (phase == 2'h0) begin
            lead_blank = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            segments <= 7'h00;
            digit_drive <= 4'h0;
            bcd_out <= 4'h0;
            bcd_oe <= 1'b0;
        end else if (clk_en) begin
            bcd_out <= cur_digit;
            // port drives only in run mode with both load controls open
            bcd_oe <= mode == bcdc_pkg::BCDC_RUN && !lr_off &&
                      !ctrl[bcdc_pkg::CTRL_LC_LO] && !load_counter_ctl &&
                      !load_register_ctl;
            if (mode == bcdc_pkg::BCDC_OFF || scan_pulse || start_load) begin
                digit_drive <= 4'h0;
                segments <= 7'h00;
            end else begin
                digit_drive <= 4'h1 << phase;
                if (disp_off || (lead_blank && !show_zeros)) begin
                    segments <= 7'h00;
                end else begin
                    segments <= bcdc_seg(cur_digit);
                end
            end
        end
    end

    // ----------
    // read channel
    // ----------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    bcdc_pkg::ADDR_CTRL: s_axi_rdata <= ctrl;
                    bcdc_pkg::ADDR_STATUS: s_axi_rdata <= {24'h0,
                        2'(mode), phase, 1'b0, carry_borrow, zero_n, equal_n};
                    bcdc_pkg::ADDR_COUNT: s_axi_rdata <= {16'h0, count};
                    bcdc_pkg::ADDR_COMPARE: s_axi_rdata <= {16'h0, compare};
                    bcdc_pkg::ADDR_LATCH: s_axi_rdata <= {16'h0, latch};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : bcdc_counter
`default_nettype wire

/* bcdc_pkg.sv */
// Purpose: constants for the four-decade bcd counter with display scan
// Assumes: 40 MHz aclk
// Notes: times are kept in their own unit and converted to cycles here
`default_nettype none
package bcdc_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    // internal scan oscillator, nominal free-running rate
    localparam int unsigned SCAN_HZ = 2500;
    localparam int unsigned SCAN_PERIOD_CYC = CLK_HZ / SCAN_HZ;
    // blanking pulse is one part in 25 of the period
    localparam int unsigned SCAN_DUTY_DIV = 25;
    localparam int unsigned SCAN_PULSE_CYC = SCAN_PERIOD_CYC / SCAN_DUTY_DIV;
    // carry/borrow pulse width in ns
    localparam int unsigned WRAP_PULSE_NS = 100;
    localparam int unsigned WRAP_PULSE_CYC =
        (WRAP_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned RESET_WRAP_MIN = 6000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [1:0] PHASE_MSD = 2'h3;
    // axi4-lite map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_COMPARE = 8'h0c;
    localparam logic [7:0] ADDR_LATCH = 8'h10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // ctrl fields
    localparam int unsigned CTRL_DIR = 0;
    localparam int unsigned CTRL_STORE_N = 1;
    localparam int unsigned CTRL_RESET_N = 2;
    localparam int unsigned CTRL_LC_LO = 3;
    localparam int unsigned CTRL_LC_HI = 4;
    localparam int unsigned CTRL_LR_LO = 5;
    localparam int unsigned CTRL_LR_HI = 6;
    localparam int unsigned CTRL_DISP_LO = 7;
    localparam int unsigned CTRL_DISP_HI = 8;
    localparam int unsigned CTRL_EXT_SCAN = 9;
    localparam int unsigned CTRL_CC = 10;
    typedef enum logic [1:0] {
        BCDC_RUN = 2'b00,
        BCDC_LOAD = 2'b01,
        BCDC_OFF = 2'b11
    } bcdc_mode_e;
endpackage : bcdc_pkg
`default_nettype wire

/* bcdc_switches.sv */
// Purpose: thumbwheel bank and wire level on the bcd port
// Assumes: digits strobed one-hot by digit_drive
// Notes: keeps the last strobed digit, capture happens on the edge that starts blanking
`default_nettype none
module bcdc_switches (
    input wire logic aclk,
    input wire logic [15:0] value,
    input wire logic cc,
    input wire logic [3:0] digit_drive,
    input wire logic bcd_oe,
    input wire logic [3:0] bcd_out,
    output logic [3:0] bcd_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'h3;
    logic [3:0] dig;
    always @(posedge aclk) begin
        if (digit_drive != 4'h0) ph <= digit_drive[3] ? 2'h3 :
            digit_drive[2] ? 2'h2 : digit_drive[1] ? 2'h1 : 2'h0;
    end
    assign dig = value[ph * 4 +: 4];
    // low-true levels on common-cathode parts
    assign bcd_wire = bcd_oe ? bcd_out : (cc ? ~dig : dig);
endmodule : bcdc_switches
`default_nettype wire

/* bcdc_tb.sv */
// Purpose: self-checking bench for bcdc_counter
// Assumes: short scan parameters, uniform switch digits
// Notes: axi tasks hold each channel until its handshake edge
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0, aresetn = 1'h0, count_in = 1'h0, cb_q = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, sw_cc = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] sw_val = 16'h0;
    logic [3:0] bcd_in, bcd_out, digit_drive, lsd;
    logic [6:0] segments;
    logic [1:0] bresp, rresp;
    logic bcd_oe, carry_borrow, equal_n, zero_n;
    logic awready, wready, bvalid, arready, rvalid;
    int n_errors = 0, comparisons = 0, n_wraps = 0;
    always #12.5 aclk = ~aclk;
    bcdc_counter #(.SCAN_PERIOD(40), .SCAN_PULSE(4)) uut (
        .aclk, .aresetn, .clk_en(1'h1), .count_in, .bcd_in, .bcd_out,
        .bcd_oe, .segments, .digit_drive, .zero_n, .carry_borrow, .equal_n,
        .ext_scan(1'h0), // no external scan source
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    bcdc_switches u_sw (.aclk, .value(sw_val), .cc(sw_cc), .digit_drive,
        .bcd_oe, .bcd_out, .bcd_wire(bcd_in));
    always @(posedge aclk) begin
        cb_q <= carry_borrow;
        if (carry_borrow === 1'h1 && cb_q !== 1'h1) n_wraps++;
    end
    // -----
    // tasks
    // -----
    task automatic summarize();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic hang();
        $display("[ERR] handshake expected done seen timeout");
        n_errors++;
        summarize();
    endtask : hang
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (i == 60) hang();
        r = bresp;
        bready <= 1'h0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int i;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (i == 60) hang();
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge aclk);
    endtask : rd
    task automatic rc(input logic [7:0] a, input string nm,
                      input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, e, d);
    endtask : rc
    task automatic ctl(input logic [31:0] v);
        logic [1:0] r;
        wr(bcdc_pkg::ADDR_CTRL, v, r);
    endtask : ctl
    task automatic pulse(input int n);
        repeat (n) begin
            count_in <= 1'h1;
            repeat (3) @(posedge aclk);
            count_in <= 1'h0;
            repeat (3) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask : pulse
    // short load pulse, then wait for run mode
    task automatic load(input logic [31:0] base, input logic [31:0] lb);
        int i;
        logic [31:0] s;
        logic [1:0] r;
        ctl(base | lb);
        ctl(base);
        for (i = 0; i < 200; i++) begin
            rd(bcdc_pkg::ADDR_STATUS, s, r);
            if (s[7:6] === 2'h0) break;
        end
        if (i == 200) hang();
    endtask : load
    task automatic quiet(input logic [31:0] v, output logic [11:0] acc);
        ctl(v);
        repeat (4) @(posedge aclk);
        acc = 12'h0;
        repeat (120) begin
            @(posedge aclk);
            acc = acc | {bcd_oe, digit_drive, segments};
            if (digit_drive[0]) lsd = bcd_out;
        end
    endtask : quiet
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rc(bcdc_pkg::ADDR_CTRL, "ctrl", bcdc_pkg::CTRL_RESET);
        rc(bcdc_pkg::ADDR_COUNT, "count", 32'h0);
        rd(8'h14, d, r);
        chk("unmapped resp", 32'h2, r);
        chk("unmapped data", 32'h0, d);
        wr(bcdc_pkg::ADDR_COUNT, 32'h1234, r);
        chk("ro write resp", 32'h2, r);
        chk("zero_n", 32'h0, zero_n);
        chk("equal_n", 32'h0, equal_n);
    endtask : t_regs
    task automatic t_count();
        int w0;
        ctl(32'h1);
        pulse(12);
        rc(bcdc_pkg::ADDR_COUNT, "up", 32'h12);
        chk("zero_n", 32'h1, zero_n);
        chk("equal_n", 32'h1, equal_n);
        rc(bcdc_pkg::ADDR_LATCH, "latch", 32'h0);
        ctl(32'h3);
        rc(bcdc_pkg::ADDR_LATCH, "store", 32'h12);
        w0 = n_wraps;
        ctl(32'h0);
        pulse(13);
        rc(bcdc_pkg::ADDR_COUNT, "down", 32'h9999);
        rc(bcdc_pkg::ADDR_LATCH, "held", 32'h12);
        ctl(32'h4);
        pulse(3);
        rc(bcdc_pkg::ADDR_COUNT, "reset", 32'h0);
        chk("wraps", w0 + 2, n_wraps);
        ctl(32'h0);
    endtask : t_count
    task automatic t_load();
        int w0;
        sw_val <= 16'h5555;
        load(32'h0, 32'h40);
        rc(bcdc_pkg::ADDR_COMPARE, "reg", 32'h5555);
        rc(bcdc_pkg::ADDR_COUNT, "cnt kept", 32'h0);
        sw_val <= 16'h7777;
        load(32'h0, 32'h10);
        rc(bcdc_pkg::ADDR_COUNT, "cnt load", 32'h7777);
        w0 = n_wraps;
        ctl(32'h4);
        rc(bcdc_pkg::ADDR_COUNT, "cleared", 32'h0);
        rc(bcdc_pkg::ADDR_COMPARE, "reg kept", 32'h5555);
        chk("reset wrap", w0 + 1, n_wraps);
        load(32'h4, 32'h40);
        rc(bcdc_pkg::ADDR_COMPARE, "reg zero", 32'h0);
        sw_val <= 16'h3333;
        sw_cc <= 1'h1;
        load(32'h400, 32'h40);
        rc(bcdc_pkg::ADDR_COMPARE, "low true", 32'h3333);
        ctl(32'h0);
    endtask : t_load
    task automatic t_disp();
        logic [11:0] acc;
        ctl(32'h1);
        pulse(21);
        quiet(32'h1, acc);
        chk("lit", 32'h1, |acc[6:0]);
        chk("port out", 32'h1, acc[11]);
        chk("lsd out", 32'h2, lsd);
        quiet(32'h101, acc);
        chk("blank", 32'h0, acc[6:0]);
        quiet(32'h21, acc);
        chk("off", 32'h0, acc);
        pulse(2);
        rc(bcdc_pkg::ADDR_COUNT, "off count", 32'h23);
    endtask : t_disp
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs();
        t_count();
        t_load();
        t_disp();
        summarize();
    end
endmodule : testbench
`default_nettype wire
